//--- logic/pfu_programmer.sv
// Sequencer that writes an update image into a 16-bit parallel NOR flash.
// Assumes the flash is wired straight to the pins and the clock is slow
// enough for a two-cycle read.
`timescale 1ns/100ps
`default_nettype none
`include "pfu_map.svh"
// Notes on behaviour
// - Each finished stage raises its own flag
// - Word address leaves on thirty-two bits
// - Sixteen-bit two-way data, one word each
// - Chip select low frames each access
// - Erase and program only area, switch word
// - Area from first address to limit
// - Erase block size chosen by flash type
// - Switch word address chosen by flash type
// - Switch word always written as fixed value
// - Input word four or two bytes wide
// - Only primary flash type selected
// - Polls bounded by counts, two cycles each
// - Every flash read spends two cycles
// - Reset input high holds, low runs
// - Word taken when ready and valid high
// - Stages run strictly in fixed order
// - Any error raises finished and failed
module pfu_programmer import pfu_pkg::*; #(
  parameter logic [31:0] erase_poll_limit   = `PFU_ERASE_POLL_LIMIT,
  parameter logic [31:0] program_poll_limit = `PFU_PROGRAM_POLL_LIMIT,
  parameter int          input_word_bytes   = `PFU_INPUT_BYTES,
  parameter int          buffer_words       = `PFU_BUFFER_WORDS
) (
  // Clock and resets
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        hold_reset_run_n,
  // Image word stream
  input  wire logic [31:0] image_word_in,
  input  wire logic        image_word_valid,
  output logic             word_accept_ready,
  // Outcome
  output logic             procedure_finished,
  output logic             procedure_failed,
  output logic             poll_timeout_fault,
  // Stage progress
  output logic             switch_erase_stage_ok,
  output logic             area_erase_stage_ok,
  output logic             area_program_stage_ok,
  output logic             verify_stage_ok,
  output logic             switch_program_stage_ok,
  // Flash pins
  output logic [31:0]      flash_word_addr_out,
  input  wire logic [15:0] flash_data_bus_in,
  output logic [15:0]      flash_data_bus_out,
  output logic             flash_data_bus_oe,
  output logic             flash_select_n,
  output logic             flash_write_n,
  output logic             flash_read_n
);
  localparam int BW = $clog2(buffer_words);
  // Type choice
  localparam logic        flash_type_primary_sel = `PFU_TYPE_PRIMARY_SEL;
  localparam logic        flash_type_alt_sel     = `PFU_TYPE_ALT_SEL;
  // Alternative type only when the primary select is off
  localparam logic        use_alt = flash_type_alt_sel & ~flash_type_primary_sel;
  localparam logic [31:0] erase_block_words = use_alt ?
    `PFU_BLOCK_WORDS_ALT : `PFU_BLOCK_WORDS_PRIMARY;
  localparam logic [31:0] switch_addr = use_alt ?
    `PFU_SWITCH_ALT : `PFU_SWITCH_PRIMARY;
  localparam logic [31:0] update_area_first_addr = `PFU_AREA_FIRST;
  localparam logic [31:0] update_area_limit_addr = `PFU_AREA_LIMIT;
  localparam logic [31:0] switch_on_value        = `PFU_SWITCH_ON;

  logic        hold;               // Combined reset
  pfu_state_t  state_q, state_d;   // Sequencer state
  pfu_phase_t  phase_q, phase_d;   // Job being polled
  logic        acc_q, acc_d;       // Second cycle of an access
  logic [31:0] ptr_q, ptr_d;       // Walking word address
  logic [31:0] base_q, base_d;     // Start of current buffer
  logic [BW-1:0] bcnt_q, bcnt_d;   // Words written in buffer
  logic        half_q, half_d;     // Upper half of a wide word
  logic [31:0] hold_q, hold_d;     // Captured image word
  logic [31:0] to_q, to_d;         // Poll loop count
  logic [4:0]  flag_q, flag_d;     // Stage flags
  logic        fin_q, fin_d;       // Finished
  logic        fail_q, fail_d;     // Failed
  logic        tmo_q, tmo_d;       // Poll timeout
  logic        is_rd, is_wr, done; // Access decode
  logic        crc_v;              // Read-back word strobe
  logic [31:0] crc;                // Running CRC
  logic [31:0] lim;                // Poll limit of current job

  assign hold = srst | hold_reset_run_n;

  // Access decode: reads and writes last two cycles each
  always_comb begin
    is_rd = state_q inside {ST_ID_RD, ST_POLL, ST_VERIFY};
    is_wr = state_q inside {ST_ID_CMD, ST_CLR, ST_ERS_SET, ST_ERS_CONF,
      ST_BUF_CMD, ST_BUF_CNT, ST_BUF_DATA, ST_BUF_CONF, ST_RD_ARR,
      ST_SW_CMD, ST_SW_DATA};
    done = (is_rd | is_wr) & acc_q;
    lim = (phase_q inside {PH_SW_ERASE, PH_AREA_ERASE}) ?
      erase_poll_limit : program_poll_limit;
  end

  // Pin drive: select framed by access states only
  always_comb begin
    flash_select_n    = ~(is_rd | is_wr);
    flash_read_n      = ~is_rd;
    flash_write_n     = ~(is_wr & ~acc_q);
    flash_data_bus_oe = is_wr;
    // Addresses are fixed or walk inside the area
    if (phase_q inside {PH_SW_ERASE, PH_SW_PROG} &&
        !(state_q inside {ST_ID_CMD, ST_ID_RD, ST_CLR, ST_RD_ARR}))
      flash_word_addr_out = switch_addr;
    else if (state_q inside {ST_ID_CMD, ST_ID_RD, ST_CLR})
      flash_word_addr_out = 32'h0000_0000;
    else if (state_q inside {ST_BUF_CNT, ST_BUF_CONF} ||
             (state_q == ST_POLL && phase_q == PH_PROG))
      flash_word_addr_out = base_q;
    else
      flash_word_addr_out = ptr_q;
    unique case (state_q)
      ST_ID_CMD:   flash_data_bus_out = `PFU_CMD_READ_ID;
      ST_CLR:      flash_data_bus_out = `PFU_CMD_CLR_STATUS;
      ST_ERS_SET:  flash_data_bus_out = `PFU_CMD_ERASE_SETUP;
      ST_BUF_CMD:  flash_data_bus_out = `PFU_CMD_BUF_PROG;
      ST_BUF_CNT:  flash_data_bus_out = 16'(buffer_words - 1);
      ST_BUF_DATA: flash_data_bus_out = half_q ? hold_q[31:16] : hold_q[15:0];
      ST_RD_ARR:   flash_data_bus_out = `PFU_CMD_READ_ARRAY;
      ST_SW_CMD:   flash_data_bus_out = `PFU_CMD_WORD_PROG;
      ST_SW_DATA:  flash_data_bus_out = switch_on_value[15:0];
      ST_ERS_CONF, ST_BUF_CONF: flash_data_bus_out = `PFU_CMD_CONFIRM;
      default:     flash_data_bus_out = 16'h0000;
    endcase
  end

  assign word_accept_ready = (state_q == ST_BUF_WAIT);
  assign crc_v = (state_q == ST_VERIFY) & done;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    acc_d   = (is_rd | is_wr) & ~acc_q;
    ptr_d   = ptr_q;
    base_d  = base_q;
    bcnt_d  = bcnt_q;
    half_d  = half_q;
    hold_d  = hold_q;
    to_d    = to_q;
    flag_d  = flag_q;
    fin_d   = fin_q;
    fail_d  = fail_q;
    tmo_d   = tmo_q;
    unique case (state_q)
      ST_IDLE:     state_d = ST_ID_CMD;
      ST_ID_CMD:   if (done) state_d = ST_ID_RD;
      ST_ID_RD: begin
        // Identifier mismatch aborts
        if (done) state_d = (flash_data_bus_in == `PFU_ID_EXPECT) ?
          ST_CLR : ST_FAIL;
      end
      ST_CLR:      if (done) state_d = ST_ERS_SET;
      ST_ERS_SET:  if (done) state_d = ST_ERS_CONF;
      ST_ERS_CONF: begin
        if (done) begin
          state_d = ST_POLL;
          to_d    = 32'h0000_0000;
        end
      end
      ST_POLL: begin
        if (done && flash_data_bus_in[`PFU_ST_READY]) begin
          if ((flash_data_bus_in & `PFU_ST_ERR_MASK) != 16'h0000) begin
            state_d = ST_FAIL;
          end else begin
            unique case (phase_q)
              PH_SW_ERASE: begin
                flag_d[0] = 1'b1;
                phase_d   = PH_AREA_ERASE;
                state_d   = ST_ERS_SET;
              end
              PH_AREA_ERASE: begin
                // Block walk ends at the limit
                if (ptr_q + erase_block_words == update_area_limit_addr)
                begin
                  flag_d[1] = 1'b1;
                  phase_d   = PH_PROG;
                  ptr_d     = update_area_first_addr;
                  state_d   = ST_BUF_CMD;
                end else begin
                  ptr_d   = ptr_q + erase_block_words;
                  state_d = ST_ERS_SET;
                end
              end
              PH_PROG: begin
                if (ptr_q == update_area_limit_addr) begin
                  flag_d[2] = 1'b1;
                  ptr_d     = update_area_first_addr;
                  state_d   = ST_RD_ARR;
                end else begin
                  state_d = ST_BUF_CMD;
                end
              end
              PH_SW_PROG: begin
                flag_d[4] = 1'b1;
                state_d   = ST_DONE;
              end
            endcase
          end
        end else if (done) begin
          // Busy read: one loop of two cycles spent
          if (to_q + 32'h0000_0001 == lim) begin
            tmo_d   = 1'b1;
            state_d = ST_FAIL;
          end else begin
            to_d = to_q + 32'h0000_0001;
          end
        end
      end
      ST_BUF_CMD: begin
        if (done) begin
          base_d  = ptr_q;
          state_d = ST_BUF_CNT;
        end
      end
      ST_BUF_CNT: begin
        if (done) begin
          bcnt_d  = '0;
          state_d = ST_BUF_WAIT;
        end
      end
      ST_BUF_WAIT: begin
        // Take a word only on ready and valid
        if (image_word_valid) begin
          hold_d  = (input_word_bytes == 2) ?
            {16'h0000, image_word_in[15:0]} : image_word_in;
          half_d  = 1'b0;
          state_d = ST_BUF_DATA;
        end
      end
      ST_BUF_DATA: begin
        if (done) begin
          ptr_d  = ptr_q + 32'h0000_0001;
          bcnt_d = bcnt_q + 1'b1;
          if (input_word_bytes == 4 && !half_q)
            half_d = 1'b1;
          else if (bcnt_q == BW'(buffer_words - 1))
            state_d = ST_BUF_CONF;
          else
            state_d = ST_BUF_WAIT;
        end
      end
      ST_BUF_CONF: begin
        if (done) begin
          state_d = ST_POLL;
          to_d    = 32'h0000_0000;
        end
      end
      ST_RD_ARR:   if (done) state_d = ST_VERIFY;
      ST_VERIFY: begin
        if (done) begin
          ptr_d = ptr_q + 32'h0000_0001;
          if (ptr_q + 32'h0000_0001 == update_area_limit_addr)
            state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (crc == `PFU_CRC_RESIDUE) begin
          flag_d[3] = 1'b1;
          phase_d   = PH_SW_PROG;
          state_d   = ST_SW_CMD;
        end else begin
          state_d = ST_FAIL;
        end
      end
      ST_SW_CMD:   if (done) state_d = ST_SW_DATA;
      ST_SW_DATA: begin
        if (done) begin
          state_d = ST_POLL;
          to_d    = 32'h0000_0000;
        end
      end
      ST_DONE:     fin_d = 1'b1;
      ST_FAIL: begin
        fin_d  = 1'b1;
        fail_d = 1'b1;
      end
      default:     state_d = ST_FAIL;
    endcase
  end

  // Sequencer registers; flags clear only in reset
  always_ff @(posedge ref_clk) begin
    if (hold) begin
      state_q <= ST_IDLE;
      phase_q <= PH_SW_ERASE;
      acc_q   <= 1'b0;
      ptr_q   <= `PFU_AREA_FIRST;
      base_q  <= `PFU_AREA_FIRST;
      bcnt_q  <= '0;
      half_q  <= 1'b0;
      hold_q  <= 32'h0000_0000;
      to_q    <= 32'h0000_0000;
      flag_q  <= 5'h00;
      fin_q   <= 1'b0;
      fail_q  <= 1'b0;
      tmo_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      acc_q   <= acc_d;
      ptr_q   <= ptr_d;
      base_q  <= base_d;
      bcnt_q  <= bcnt_d;
      half_q  <= half_d;
      hold_q  <= hold_d;
      to_q    <= to_d;
      flag_q  <= flag_d;
      fin_q   <= fin_d;
      fail_q  <= fail_d;
      tmo_q   <= tmo_d;
    end
  end

  // Read-back CRC, cleared with the sequencer
  pfu_crc32 u_crc (
    .ref_clk (ref_clk),
    .srst    (hold),
    .valid   (crc_v),
    .data    (flash_data_bus_in),
    .crc_q   (crc)
  );

  assign procedure_finished      = fin_q;
  assign procedure_failed        = fail_q;
  assign poll_timeout_fault      = tmo_q;
  assign switch_erase_stage_ok   = flag_q[0];
  assign area_erase_stage_ok     = flag_q[1];
  assign area_program_stage_ok   = flag_q[2];
  assign verify_stage_ok         = flag_q[3];
  assign switch_program_stage_ok = flag_q[4];

  // Checks on the sequencer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (hold);
  property p_idle_quiet;
    state_q inside {ST_IDLE, ST_BUF_WAIT, ST_CHECK, ST_DONE, ST_FAIL} |->
      flash_select_n && flash_write_n && flash_read_n && !flash_data_bus_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("select or bus active outside an access");
  property p_read_two;
    (is_rd && !acc_q) |=> $stable(state_q) && acc_q ##1 !$stable(acc_q);
  endproperty
  a_read_two: assert property (p_read_two)
    else $error("read access not two cycles");
  property p_capture;
    word_accept_ready && image_word_valid |=> state_q == ST_BUF_DATA &&
      hold_q[15:0] == $past(image_word_in[15:0]) &&
      hold_q[31:16] == ((input_word_bytes == 2) ? 16'h0000 :
      $past(image_word_in[31:16]));
  endproperty
  a_capture: assert property (p_capture)
    else $error("image word not captured");
  property p_fail_done;
    $rose(fail_q) |-> fin_q;
  endproperty
  a_fail_done: assert property (p_fail_done)
    else $error("failure without finish");
  property p_sticky;
    (flag_q != 5'h00) |=> (flag_q & $past(flag_q)) == $past(flag_q);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("stage flag dropped");
  property p_order;
    $rose(flag_q[4]) |-> flag_q[3:0] == 4'hF;
  endproperty
  a_order: assert property (p_order)
    else $error("stages out of order");
  property p_range;
    state_q inside {ST_ERS_CONF, ST_BUF_DATA, ST_BUF_CONF, ST_SW_DATA} |->
      flash_word_addr_out == switch_addr ||
      (flash_word_addr_out >= update_area_first_addr &&
       flash_word_addr_out < update_area_limit_addr);
  endproperty
  a_range: assert property (p_range)
    else $error("erase or program outside allowed range");
  property p_switch_val;
    state_q == ST_SW_DATA && !flash_write_n |->
      flash_data_bus_out == switch_on_value[15:0];
  endproperty
  a_switch_val: assert property (p_switch_val)
    else $error("wrong switch word value");
  property p_timeout;
    $rose(tmo_q) |-> state_q == ST_FAIL ##1 fail_q;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not fail the procedure");
  c_good: cover property (fin_q && !fail_q);
  c_take: cover property (word_accept_ready && image_word_valid);
  c_tmo:  cover property ($rose(tmo_q));
endmodule
`default_nettype wire

//--- shared/pfu_map.svh
// Constants of the parallel flash update programmer: commands, status
// bits, address map, timeout counts and reset values.
// Assumes a 16-bit NOR flash with the common command set.
`ifndef PFU_MAP_SVH
`define PFU_MAP_SVH
// Flash type selection, only the primary type is selected
`define PFU_TYPE_PRIMARY_SEL    1'b1
`define PFU_TYPE_ALT_SEL        1'b0
// Erase block sizes in words
`define PFU_BLOCK_WORDS_PRIMARY 32'h0001_0000
`define PFU_BLOCK_WORDS_ALT     32'h0002_0000
// Update area, first word and one past the last word
`define PFU_AREA_FIRST          32'h0010_0000
`define PFU_AREA_LIMIT          32'h0020_0000
// Switch word location and its on value
`define PFU_SWITCH_PRIMARY      32'h0000_FFFE
`define PFU_SWITCH_ALT          32'h0001_FFFE
`define PFU_SWITCH_ON           32'h0000_00BB
// Input word width in bytes, 4 or 2
`define PFU_INPUT_BYTES         4
// Poll limits in loops of two clock cycles
`define PFU_ERASE_POLL_LIMIT    32'h0200_0000
`define PFU_PROGRAM_POLL_LIMIT  32'h0000_9000
`define PFU_CYCLES_PER_POLL     2
// Program buffer depth in words
`define PFU_BUFFER_WORDS        512
// Expected identifier word, arbitrary value
`define PFU_ID_EXPECT           16'h0001
// Flash commands
`define PFU_CMD_READ_ID         16'h0090
`define PFU_CMD_CLR_STATUS      16'h0050
`define PFU_CMD_ERASE_SETUP     16'h0020
`define PFU_CMD_CONFIRM         16'h00D0
`define PFU_CMD_BUF_PROG        16'h00E8
`define PFU_CMD_WORD_PROG       16'h0040
`define PFU_CMD_READ_ARRAY      16'h00FF
// Status word bits
`define PFU_ST_READY            7
`define PFU_ST_ERR_MASK         16'h003A
// Check word after the image and its trailing CRC
`define PFU_CRC_POLY            32'h04C1_1DB7
`define PFU_CRC_RESIDUE         32'hC704_DD7B
`endif

//--- shared/pfu_pkg.sv
// Types of the parallel flash update programmer.
// Assumes nothing beyond the constants header.
package pfu_pkg;
  // Sequencer states, Gray coded along the main path
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00000,
    ST_ID_CMD   = 5'b00001,
    ST_ID_RD    = 5'b00011,
    ST_CLR      = 5'b00010,
    ST_ERS_SET  = 5'b00110,
    ST_ERS_CONF = 5'b00111,
    ST_POLL     = 5'b00101,
    ST_BUF_CMD  = 5'b00100,
    ST_BUF_CNT  = 5'b01100,
    ST_BUF_WAIT = 5'b01101,
    ST_BUF_DATA = 5'b01111,
    ST_BUF_CONF = 5'b01110,
    ST_RD_ARR   = 5'b01010,
    ST_VERIFY   = 5'b01011,
    ST_CHECK    = 5'b01001,
    ST_SW_CMD   = 5'b01000,
    ST_SW_DATA  = 5'b11000,
    ST_DONE     = 5'b11001,
    ST_FAIL     = 5'b11011
  } pfu_state_t;
  // Which erase or program job the poll belongs to
  typedef enum logic [1:0] {
    PH_SW_ERASE   = 2'b00,
    PH_AREA_ERASE = 2'b01,
    PH_PROG       = 2'b11,
    PH_SW_PROG    = 2'b10
  } pfu_phase_t;
endpackage

//--- logic/pfu_crc32.sv
// CRC32 over the words read back, low byte first, msb of a byte first.
// Assumes one data word per valid pulse.
`timescale 1ns/100ps
`default_nettype none
module pfu_crc32 (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Word stream
  input  wire logic        valid,
  input  wire logic [15:0] data,
  // Running CRC
  output logic      [31:0] crc_q
);
  `include "pfu_map.svh"
  logic [31:0] crc_d;   // Next CRC
  // Fold sixteen bits into the CRC
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_d = crc_q;
    if (valid) begin
      for (int i = 0; i < 16; i++) begin
        fb = crc_d[31] ^ data[(i < 8) ? (7 - i) : (23 - i)];
        crc_d = {crc_d[30:0], 1'b0} ^ (fb ? `PFU_CRC_POLY : 32'h0000_0000);
      end
    end
  end
  // Register, starting from all ones
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      crc_q <= 32'hFFFF_FFFF;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule
`default_nettype wire

//--- dv/pfu_flash_model.sv
// Behavioural 16-bit parallel NOR flash seen from the programmer's pins.
// Assumes two-cycle reads and a write strobe low for one cycle per write.
`timescale 1ns/100ps
`default_nettype none
module pfu_flash_model (
  // Clock
  input  wire logic        ref_clk,
  // Flash pins
  input  wire logic [15:0] flash_data_bus_out,
  input  wire logic        flash_select_n,
  input  wire logic        flash_write_n,
  input  wire logic        flash_read_n,
  output logic      [15:0] flash_data_bus_in,
  // Behaviour knobs
  input  wire logic [15:0] id_word,
  input  wire logic [7:0]  busy_reads,
  input  wire logic        never_ready,
  input  wire logic [15:0] err_bits,
  // Completed reads since the last write
  output logic      [7:0]  reads_q
);
  logic [15:0] cmd_q;   // Last word written
  logic        phase_q; // High in the second cycle of a read
  logic [15:0] last_q;  // Last word driven onto the bus
  logic [15:0] word;    // Word answered by the current read

  initial begin
    cmd_q   = 16'h0000;
    phase_q = 1'b0;
    last_q  = 16'h0000;
    reads_q = 8'h00;
  end

  // Identifier after its command, otherwise the status word
  always_comb begin
    if (cmd_q == 16'h0090) begin
      word = id_word;
    end else if (!never_ready && reads_q >= busy_reads) begin
      word = 16'h0080 | err_bits;
    end else begin
      word = 16'h0000;
    end
  end

  // A released bus never keeps showing the last word
  assign flash_data_bus_in = (!flash_select_n && !flash_read_n) ? word
                                                               : ~last_q;

  // Writes restart the read count; reads complete every second cycle
  always @(posedge ref_clk) begin
    if (!flash_select_n && !flash_write_n) begin
      cmd_q   <= flash_data_bus_out;
      reads_q <= 8'h00;
      phase_q <= 1'b0;
    end else if (!flash_select_n && !flash_read_n) begin
      phase_q <= !phase_q;
      last_q  <= word;
      if (phase_q) begin
        reads_q <= reads_q + 8'h01;
      end
    end else begin
      phase_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/parallel_flash_update_programmer_tb.sv
// Self-checking bench for the parallel flash update programmer.
// Assumes the flash model beside it and small poll limits.
`timescale 1ns/100ps
`default_nettype none
`include "pfu_map.svh"
module parallel_flash_update_programmer_tb;
  import pfu_pkg::*;
  logic        ref_clk, srst, hold_reset_run_n, image_word_valid;
  logic [31:0] image_word_in, flash_word_addr_out;
  logic        word_accept_ready, procedure_finished, procedure_failed;
  logic        poll_timeout_fault, switch_erase_stage_ok;
  logic        area_erase_stage_ok, area_program_stage_ok;
  logic        verify_stage_ok, switch_program_stage_ok;
  logic [15:0] flash_data_bus_in, flash_data_bus_out, id_word, err_bits;
  logic        flash_data_bus_oe, flash_select_n, flash_write_n;
  logic        flash_read_n, never_ready;
  logic [7:0]  busy_reads, reads_q;
  logic [31:0] wa_q[$];  // Write addresses seen on the pins
  logic [15:0] wd_q[$];  // Write data seen on the pins
  int          fails, checked, cycles, n;

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  pfu_programmer #(.erase_poll_limit(32'h0000_0008),
    .program_poll_limit(32'h0000_0008), .input_word_bytes(4)) dut (
    .ref_clk(ref_clk), .srst(srst), .hold_reset_run_n(hold_reset_run_n),
    .image_word_in(image_word_in), .image_word_valid(image_word_valid),
    .word_accept_ready(word_accept_ready),
    .procedure_finished(procedure_finished),
    .procedure_failed(procedure_failed),
    .poll_timeout_fault(poll_timeout_fault),
    .switch_erase_stage_ok(switch_erase_stage_ok),
    .area_erase_stage_ok(area_erase_stage_ok),
    .area_program_stage_ok(area_program_stage_ok),
    .verify_stage_ok(verify_stage_ok),
    .switch_program_stage_ok(switch_program_stage_ok),
    .flash_word_addr_out(flash_word_addr_out),
    .flash_data_bus_in(flash_data_bus_in),
    .flash_data_bus_out(flash_data_bus_out),
    .flash_data_bus_oe(flash_data_bus_oe), .flash_select_n(flash_select_n),
    .flash_write_n(flash_write_n), .flash_read_n(flash_read_n));

  pfu_flash_model flash (
    .ref_clk(ref_clk), .flash_data_bus_out(flash_data_bus_out),
    .flash_select_n(flash_select_n), .flash_write_n(flash_write_n),
    .flash_read_n(flash_read_n), .flash_data_bus_in(flash_data_bus_in),
    .id_word(id_word), .busy_reads(busy_reads), .never_ready(never_ready),
    .err_bits(err_bits), .reads_q(reads_q));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // Record every write access; the bus is driven at its write strobe
  always @(posedge ref_clk) begin
    if (!flash_select_n && !flash_write_n) begin
      wa_q.push_back(flash_word_addr_out);
      wd_q.push_back(flash_data_bus_out);
      check("bus_oe", {31'h0, flash_data_bus_oe}, 32'h1);
    end
  end

  // Hold in reset two cycles with new flash behaviour, then run
  task automatic start(input logic [15:0] id, input logic nr,
                       input logic [15:0] err);
    @(posedge ref_clk);
    hold_reset_run_n <= 1'b1;
    id_word          <= id;
    never_ready      <= nr;
    err_bits         <= err;
    repeat (2) @(posedge ref_clk);
    wa_q.delete();
    wd_q.delete();
    hold_reset_run_n <= 1'b0;
  endtask

  // Wait for finished (0) or ready (1), bounded
  task automatic wait_sig(input int which);
    for (n = 0; n < 3000; n++) begin
      @(negedge ref_clk);
      if ((which == 0 ? procedure_finished : word_accept_ready) === 1'b1)
        break;
    end
    check("wait_bound", {31'h0, (n < 3000)}, 32'h1);
  endtask

  // Offer one image word until it is taken
  task automatic send(input logic [31:0] w);
    @(posedge ref_clk);
    image_word_valid <= 1'b1;
    image_word_in    <= w;
    do @(negedge ref_clk); while (word_accept_ready !== 1'b1);
    @(posedge ref_clk);
    image_word_valid <= 1'b0;
    image_word_in    <= ~w;
    @(negedge ref_clk);
    check("ready_drop", {31'h0, word_accept_ready}, 32'h0);
  endtask

  // Count writes of one data value
  function automatic int count_data(input logic [15:0] v);
    count_data = 0;
    foreach (wd_q[i]) if (wd_q[i] === v) count_data++;
  endfunction

  // Outcome and stage flags in one go
  task automatic outcome(input logic [2:0] exp, input logic [1:0] ok);
    check("outcome", {29'h0, procedure_finished, procedure_failed,
          poll_timeout_fault}, {29'h0, exp});
    check("stage_ok", {27'h0, switch_program_stage_ok, verify_stage_ok,
          area_program_stage_ok, switch_erase_stage_ok,
          area_erase_stage_ok}, {27'h0, 3'b000, ok});
  endtask

  initial begin
    srst = 1'b1;
    hold_reset_run_n = 1'b1;
    image_word_valid = 1'b0;
    image_word_in = 32'h0000_0000;
    id_word = 16'h0001;
    busy_reads = 8'h03;
    never_ready = 1'b0;
    err_bits = 16'h0000;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset_pins", {28'h0, flash_select_n, flash_data_bus_oe,
          word_accept_ready, procedure_finished}, 32'h8);
    @(posedge ref_clk);
    srst <= 1'b0;
    // Wrong identifier stops before any erase
    start(16'h1234, 1'b0, 16'h0000);
    wait_sig(0);
    outcome(3'b110, 2'b00);
    check("no_erase", count_data(16'h0020), 32'h0);
    $display("test wrong_id done");
    // Flash never ready: fault after the poll limit
    start(16'h0001, 1'b1, 16'h0000);
    wait_sig(0);
    outcome(3'b111, 2'b00);
    check("poll_reads", {24'h0, reads_q}, 32'h8);
    $display("test timeout done");
    // Status error bit fails without a timeout
    start(16'h0001, 1'b0, 16'h0020);
    wait_sig(0);
    outcome(3'b110, 2'b00);
    $display("test status_error done");
    // Good run up to the first image words
    start(16'h0001, 1'b0, 16'h0000);
    wait_sig(1);
    outcome(3'b000, 2'b11);
    check("prog_ok", {31'h0, area_program_stage_ok}, 32'h0);
    check("confirms", count_data(16'h00D0), 32'd17);
    n = 0;
    foreach (wd_q[i]) if (wd_q[i] === 16'h00D0) begin
      check("erase_addr", wa_q[i], (n == 0) ? `PFU_SWITCH_PRIMARY :
            `PFU_AREA_FIRST + (n - 1) * `PFU_BLOCK_WORDS_PRIMARY);
      n++;
    end
    wa_q.delete();
    wd_q.delete();
    send(32'hA5A5_1234);
    send(32'h0F0F_5A5A);
    repeat (8) @(posedge ref_clk);
    check("writes", wd_q.size(), 32'd4);
    for (n = 0; n < 4; n++) begin
      check("data_addr", wa_q[n], `PFU_AREA_FIRST + n);
      check("data_word", {16'h0, wd_q[n]}, {16'h0,
            n[1] ? (n[0] ? 16'h0F0F : 16'h5A5A)
                 : (n[0] ? 16'hA5A5 : 16'h1234)});
    end
    // Hold again mid-run: flags and pins return to rest
    @(posedge ref_clk);
    hold_reset_run_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    outcome(3'b000, 2'b00);
    check("hold_pins", {30'h0, flash_select_n, flash_data_bus_oe},
          32'h2);
    $display("test good_run done");
    final_report();
  end
endmodule
`default_nettype wire
